//--- src/p0lpc_map.svh
`ifndef P0LPC_MAP_SVH
`define P0LPC_MAP_SVH

// Register offsets (byte addresses on the local register port)
`define P0LPC_FUNC_ADDR      8'he7
`define P0LPC_FLAGS_ADDR     8'he8
`define P0LPC_STAT_ADDR      8'hf0
`define P0LPC_MASK_ADDR      8'hf1

// Reset values
`define P0LPC_FUNC_RST       8'h00
`define P0LPC_FLAGS_RST      4'h0

// Field positions in the pin-function register
`define P0LPC_PIN3_LSB       6
`define P0LPC_PIN2_LSB       4
`define P0LPC_PIN1_LSB       2
`define P0LPC_PIN0_LSB       0

// Bit positions in the edge interrupt flags register
`define P0LPC_EN1_BIT        3
`define P0LPC_PND1_BIT       2
`define P0LPC_EN0_BIT        1
`define P0LPC_PND0_BIT       0

// Pin mode encodings
`define P0LPC_MODE_IN        2'h0
`define P0LPC_MODE_IN_PU     2'h1
`define P0LPC_MODE_OUT       2'h2
`define P0LPC_MODE_ANA       2'h3

`endif

//--- src/p0lpc_pkg.sv
package p0lpc_pkg;

   // Decoded controls for one pin
   typedef struct packed {
      logic schmitt_en;
      logic pull_up;
      logic out_en;
      logic analog_sel;
   } p0lpc_pin_ctl_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } p0lpc_bus_req_t;

   // Edge detector state
   typedef enum logic [2:0] {
      P0LPC_ST_IDLE  = 3'b001,
      P0LPC_ST_HIGH  = 3'b010,
      P0LPC_ST_LOW   = 3'b100
   } p0lpc_edge_st_t;

endpackage

//--- src/p0lpc_pin_dec.sv
`timescale 1ns/1ps
`include "p0lpc_map.svh"

// Decode one two-bit pin-function field into pad controls
module p0lpc_pin_dec
(
   // Field in
   input  wire logic [1:0]              mode_i,
   // Controls out
   output p0lpc_pkg::p0lpc_pin_ctl_t    ctl_o
);

   // Analog mode turns the Schmitt path off to avoid crowbar current
   always_comb
   begin
      ctl_o = '0;
      case (mode_i)
         `P0LPC_MODE_IN:
         begin
            ctl_o.schmitt_en = 1'b1;
         end
         `P0LPC_MODE_IN_PU:
         begin
            ctl_o.schmitt_en = 1'b1;
            ctl_o.pull_up    = 1'b1;
         end
         `P0LPC_MODE_OUT:
         begin
            ctl_o.out_en     = 1'b1;
         end
         `P0LPC_MODE_ANA:
         begin
            ctl_o.analog_sel = 1'b1;
         end
         default:
         begin
            ctl_o = '0;
         end
      endcase
   end

endmodule

//--- src/p0lpc_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "p0lpc_map.svh"

// Behaviour
// RULE1: Pins three and two decode 00 input, 01 input with pull-up, 10 push-pull output, 11 analog with Schmitt off.
// RULE2: Pin one decodes 00 interrupt input, 01 interrupt input with pull-up, 10 output, 11 analog with Schmitt off.
// RULE3: Pin zero uses the same four-way decode as pin one.
// RULE4: Flags bit 3 enables the pin one edge interrupt and bit 1 that of pin zero; both are read-write.
// RULE5: Flags bit 2 reads the pin one pending state; writing 0 clears it and writing 1 leaves it.
// RULE6: Flags bit 0 reads the pin zero pending state; writing 0 clears it and writing 1 leaves it.
// RULE7: A falling edge on an interrupt-mode pin sets its flag, and a request is raised while flag and enable are both set.
module p0lpc_top
(
   // Clock and reset
   input  wire logic                    core_clk_i,
   input  wire logic                    arst_n_i,
   // Register port
   input  wire logic [7:0]              reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic      [7:0]              reg_rdata_o,
   // Pins, sampled synchronously
   input  wire logic [3:0]              pin_in_i,
   input  wire logic [3:0]              pin_out_val_i,
   // Pad controls
   output logic      [3:0]              pin_o,
   output logic      [3:0]              pin_oe_o,
   output logic      [3:0]              pull_up_o,
   output logic      [3:0]              schmitt_en_o,
   output logic      [3:0]              analog_sel_o,
   // Interrupt requests
   output logic                         edge_irq_line_zero_o,
   output logic                         edge_irq_line_one_o,
   output logic                         irq_o
);

   p0lpc_pkg::p0lpc_bus_req_t           req;
   p0lpc_pkg::p0lpc_pin_ctl_t [3:0]     ctl;
   p0lpc_pkg::p0lpc_edge_st_t [1:0]     edge_st_r;
   logic      [7:0]                     func_r;
   logic      [1:0]                     en_r;
   logic      [1:0]                     pnd_r;
   logic      [1:0]                     stat_r;
   logic      [1:0]                     mask_r;
   logic      [1:0]                     fall;
   logic      [1:0]                     irq_mode;
   logic      [1:0]                     pnd_clr;
   logic      [1:0]                     stat_clr;
   logic      [7:0]                     rdata_nxt;
   logic                                wr_func;
   logic                                wr_flags;
   logic                                wr_stat;
   logic                                wr_mask;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                  wr: reg_wr_i, rd: reg_rd_i};

   // Address decode of write strobes
   assign wr_func  = req.wr && (req.addr == `P0LPC_FUNC_ADDR);
   assign wr_flags = req.wr && (req.addr == `P0LPC_FLAGS_ADDR);
   assign wr_stat  = req.wr && (req.addr == `P0LPC_STAT_ADDR);
   assign wr_mask  = req.wr && (req.addr == `P0LPC_MASK_ADDR);

   // Pin-function register
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         func_r <= `P0LPC_FUNC_RST;
      else if (wr_func)
         func_r <= req.wdata;
   end

   // One decoder per pin field
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_dec
         p0lpc_pin_dec u_dec
         (
            .mode_i (func_r[2*g +: 2]),                 // RULE1 RULE2 RULE3
            .ctl_o  (ctl[g])
         );
      end
   endgenerate

   // Pad controls registered so the outputs come from flops
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pin_o        <= 4'h0;
         pin_oe_o     <= 4'h0;
         pull_up_o    <= 4'h0;
         schmitt_en_o <= 4'h0;
         analog_sel_o <= 4'h0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            pin_o[i]        <= pin_out_val_i[i] & ctl[i].out_en;
            pin_oe_o[i]     <= ctl[i].out_en;      // RULE1 RULE2 RULE3
            pull_up_o[i]    <= ctl[i].pull_up;
            schmitt_en_o[i] <= ctl[i].schmitt_en;
            analog_sel_o[i] <= ctl[i].analog_sel;
         end
      end
   end

   // Only the two low pins can interrupt, and only in input modes
   assign irq_mode[0] = ctl[0].schmitt_en;                     // RULE3
   assign irq_mode[1] = ctl[1].schmitt_en;                     // RULE2

   // Edge tracker re-arms on entering an input mode, so leaving output mode
   // with the pin low never fakes an edge
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         edge_st_r[0] <= p0lpc_pkg::P0LPC_ST_IDLE;
         edge_st_r[1] <= p0lpc_pkg::P0LPC_ST_IDLE;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!irq_mode[i])
               edge_st_r[i] <= p0lpc_pkg::P0LPC_ST_IDLE;
            else
            begin
               case (edge_st_r[i])
                  p0lpc_pkg::P0LPC_ST_IDLE:
                     edge_st_r[i] <= pin_in_i[i] ? p0lpc_pkg::P0LPC_ST_HIGH
                                                 : p0lpc_pkg::P0LPC_ST_LOW;
                  p0lpc_pkg::P0LPC_ST_HIGH:
                     if (!pin_in_i[i])
                        edge_st_r[i] <= p0lpc_pkg::P0LPC_ST_LOW;
                  p0lpc_pkg::P0LPC_ST_LOW:
                     if (pin_in_i[i])
                        edge_st_r[i] <= p0lpc_pkg::P0LPC_ST_HIGH;
                  default:
                     edge_st_r[i] <= p0lpc_pkg::P0LPC_ST_IDLE;
               endcase
            end
         end
      end
   end

   // Falling edge: tracked high, pin now low
   always_comb
   begin
      for (int i = 0; i < 2; i++)
         fall[i] = irq_mode[i] && !pin_in_i[i]
                   && (edge_st_r[i] == p0lpc_pkg::P0LPC_ST_HIGH); // RULE7
   end

   // Pending clear by writing zero
   assign pnd_clr[0] = wr_flags && !req.wdata[`P0LPC_PND0_BIT];    // RULE6
   assign pnd_clr[1] = wr_flags && !req.wdata[`P0LPC_PND1_BIT];    // RULE5

   // Enable bits
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         en_r <= 2'h0;
      else if (wr_flags)
      begin
         en_r[0] <= req.wdata[`P0LPC_EN0_BIT];                    // RULE4
         en_r[1] <= req.wdata[`P0LPC_EN1_BIT];                    // RULE4
      end
   end

   // Pending flags; a new edge wins over a clear in the same cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pnd_r <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (fall[i])
               pnd_r[i] <= 1'b1;                                  // RULE7
            else if (pnd_clr[i])
               pnd_r[i] <= 1'b0;                                  // RULE5 RULE6
         end
      end
   end

   // Summary status, write-one-to-clear, set wins
   assign stat_clr = wr_stat ? req.wdata[1:0] : 2'h0;
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         stat_r <= 2'h0;
      else
         stat_r <= fall | (stat_r & ~stat_clr);
   end

   // Summary mask
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         mask_r <= 2'h0;
      else if (wr_mask)
         mask_r <= req.wdata[1:0];
   end

   // Request lines follow flag and enable, and irq_o follows status and mask, one cycle later
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         edge_irq_line_zero_o <= 1'b0;
         edge_irq_line_one_o  <= 1'b0;
         irq_o                <= 1'b0;
      end
      else
      begin
         edge_irq_line_zero_o <= pnd_r[0] & en_r[0];              // RULE7
         edge_irq_line_one_o  <= pnd_r[1] & en_r[1];              // RULE7
         irq_o                <= |(stat_r & mask_r);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      case (req.addr)
         `P0LPC_FUNC_ADDR:  rdata_nxt = func_r;
         `P0LPC_FLAGS_ADDR: rdata_nxt = {4'h0, en_r[1], pnd_r[1],
                                         en_r[0], pnd_r[0]};  // RULE4 RULE5 RULE6
         `P0LPC_STAT_ADDR:  rdata_nxt = {6'h00, stat_r};
         `P0LPC_MASK_ADDR:  rdata_nxt = {6'h00, mask_r};
         default:           rdata_nxt = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         reg_rdata_o <= 8'h00;
      else if (req.rd)
         reg_rdata_o <= rdata_nxt;
      else
         reg_rdata_o <= 8'h00;
   end

   // Assertions
   sequence s_fall0;
      irq_mode[0] && edge_st_r[0] == p0lpc_pkg::P0LPC_ST_HIGH
      && !pin_in_i[0];
   endsequence

   sequence s_req0;
      pnd_r[0] && en_r[0];
   endsequence

   property p_pin3_out;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      func_r[7:6] == `P0LPC_MODE_OUT |=> pin_oe_o[3];
   endproperty
   a_pin3_out: assert property (p_pin3_out)                      // RULE1
      else $error("pin three not driven in output mode");

   property p_pin2_ana;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      func_r[5:4] == `P0LPC_MODE_ANA |=> analog_sel_o[2] && !schmitt_en_o[2];
   endproperty
   a_pin2_ana: assert property (p_pin2_ana)                      // RULE1
      else $error("pin two analog mode wrong");

   property p_pin1_pu;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      func_r[3:2] == `P0LPC_MODE_IN_PU |=> pull_up_o[1] && !pin_oe_o[1];
   endproperty
   a_pin1_pu: assert property (p_pin1_pu)                        // RULE2
      else $error("pin one pull-up mode wrong");

   property p_pin0_noirq;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      func_r[1:0] == `P0LPC_MODE_ANA && !pnd_r[0]
      |=> !pnd_r[0];
   endproperty
   a_pin0_noirq: assert property (p_pin0_noirq)                  // RULE3
      else $error("pin zero flagged in analog mode");

   property p_en_write;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      wr_flags |=> en_r == {$past(req.wdata[3]), $past(req.wdata[1])};
   endproperty
   a_en_write: assert property (p_en_write)                      // RULE4
      else $error("enable bits not written");

   property p_clr1;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      pnd_clr[1] && !fall[1] |=> !pnd_r[1];
   endproperty
   a_clr1: assert property (p_clr1)                              // RULE5
      else $error("pin one flag not cleared");

   property p_keep0;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      wr_flags && req.wdata[0] && pnd_r[0] |=> pnd_r[0];
   endproperty
   a_keep0: assert property (p_keep0)                            // RULE6
      else $error("pin zero flag lost on write of one");

   property p_set0;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_fall0 |=> pnd_r[0];
   endproperty
   a_set0: assert property (p_set0)                              // RULE7
      else $error("pin zero edge not flagged");

   property p_line0;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_req0 |=> edge_irq_line_zero_o;
   endproperty
   a_line0: assert property (p_line0)                            // RULE7
      else $error("pin zero request not raised");

endmodule

//--- tb/p0lpc_pin_model.sv
`timescale 1ns/1ps

// Pad and board model: sets the level seen on each of the four pins
module p0lpc_pin_model
(
   // Clock
   input  wire logic       core_clk_i,
   // Pad controls from the block
   input  wire logic [3:0] pin_o,
   input  wire logic [3:0] pin_oe_o,
   input  wire logic [3:0] pull_up_o,
   // Board drive from the bench
   input  wire logic [3:0] ext_en_i,
   input  wire logic [3:0] ext_val_i,
   // Level back into the block
   output logic      [3:0] level_o
);
   logic [3:0] float_r;

   // A pin nobody drives keeps changing, so a stale level is never trusted
   initial
   begin
      float_r = 4'h5;
      forever @(posedge core_clk_i) float_r <= ~float_r;
   end

   // Own driver wins, then the board, then the pull-up
   always_comb
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (pin_oe_o[p])
            level_o[p] = pin_o[p];
         else if (ext_en_i[p])
            level_o[p] = ext_val_i[p];
         else if (pull_up_o[p])
            level_o[p] = 1'b1;
         else
            level_o[p] = float_r[p];
      end
   end
endmodule

//--- tb/test_port0_low_pin_config_extint.sv
`timescale 1ns/1ps

// Self-checking bench for the low pin function and edge interrupt block
module test_port0_low_pin_config_extint;
   logic       core_clk_i;
   logic       arst_n_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic       reg_wr_i;
   logic       reg_rd_i;
   logic [7:0] reg_rdata_o;
   logic [3:0] pin_in_i;
   logic [3:0] pin_out_val_i;
   logic [3:0] pin_o;
   logic [3:0] pin_oe_o;
   logic [3:0] pull_up_o;
   logic [3:0] schmitt_en_o;
   logic [3:0] analog_sel_o;
   logic       edge_irq_line_zero_o;
   logic       edge_irq_line_one_o;
   logic       irq_o;
   logic [3:0] ext_en;
   logic [3:0] ext_val;
   int         mismatches;
   int         compares;
   int         seed;
   logic [31:0] r;
   logic [7:0] func;
   logic [7:0] d;
   logic [3:0] e_s, e_p, e_o, e_a;
   logic [3:0] ctl;
   logic       pe;
   logic [7:0] addrs [5];

   p0lpc_top i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .pin_in_i(pin_in_i), .pin_out_val_i(pin_out_val_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
      .schmitt_en_o(schmitt_en_o), .analog_sel_o(analog_sel_o),
      .edge_irq_line_zero_o(edge_irq_line_zero_o),
      .edge_irq_line_one_o(edge_irq_line_one_o), .irq_o(irq_o));

   p0lpc_pin_model i_pins (.core_clk_i(core_clk_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .level_o(pin_in_i));

   // Clock at 40 MHz
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   // Expected pad controls {schmitt, pull, drive, analog} for one field
   function automatic logic [3:0] exp_ctl(input logic [1:0] m);
      case (m)
         2'h0:    return 4'h8;
         2'h1:    return 4'hc;
         2'h2:    return 4'h2;
         default: return 4'h1;
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #(20000 * 25);
      mismatches++;
      results();
   end

   // Main sequence
   initial
   begin
      arst_n_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      pin_out_val_i = 4'h0;
      ext_en = 4'hf;
      ext_val = 4'hf;
      mismatches = 0;
      compares = 0;
      seed = 32'h67db8827;
      addrs = '{8'he7, 8'he8, 8'hf0, 8'hf1, 8'h55};
      repeat (12) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      // Reset values, and an unmapped place reads zero
      foreach (addrs[i])
      begin
         rd(addrs[i], d);
         chk(d, 8'h00);
      end
      // Random pin functions with every mode on every pin
      for (int k = 0; k < 24; k++)
      begin
         r = $random(seed);
         func = (k < 4) ? {4{k[1:0]}} : r[7:0];
         @(posedge core_clk_i);
         pin_out_val_i <= r[11:8];
         wr(8'he7, func);
         repeat (3) @(posedge core_clk_i);
         #1;
         for (int p = 0; p < 4; p++)
         begin
            ctl = exp_ctl(func[2*p +: 2]);
            {e_s[p], e_p[p], e_o[p], e_a[p]} = ctl;
         end
         chk({4'h0, schmitt_en_o}, {4'h0, e_s});
         chk({4'h0, pull_up_o}, {4'h0, e_p});
         chk({4'h0, pin_oe_o}, {4'h0, e_o});
         chk({4'h0, analog_sel_o}, {4'h0, e_a});
         chk({4'h0, pin_o}, {4'h0, e_o & r[11:8]});
         rd(8'he7, d);
         chk(d, func);
      end
      // Falling edges on pins zero and one in each mode
      for (int m = 0; m < 4; m++)
      begin
         pe = (m < 2);
         wr(8'hf1, 8'h01);
         wr(8'he7, {4'h0, m[1:0], m[1:0]});
         @(posedge core_clk_i);
         ext_val <= 4'hf;
         repeat (3) @(posedge core_clk_i);
         wr(8'he8, 8'h0a);
         wr(8'hf0, 8'h03);
         @(posedge core_clk_i);
         ext_val <= 4'hc;
         repeat (4) @(posedge core_clk_i);
         rd(8'he8, d);
         chk(d, pe ? 8'h0f : 8'h0a);
         chk({edge_irq_line_one_o, edge_irq_line_zero_o}, {pe, pe});
         chk(irq_o, pe);
         rd(8'hf0, d);
         chk(d, pe ? 8'h03 : 8'h00);
         // Mask selects which sticky bit reaches the summary output
         wr(8'hf1, 8'h02);
         repeat (2) @(posedge core_clk_i);
         #1;
         chk(irq_o, pe);
         wr(8'hf0, 8'h02);
         repeat (2) @(posedge core_clk_i);
         #1;
         chk(irq_o, 1'b0);
         rd(8'hf0, d);
         chk(d, pe ? 8'h01 : 8'h00);
         // Writing ones keeps the flags and the enables
         wr(8'he8, 8'h0f);
         rd(8'he8, d);
         chk(d, pe ? 8'h0f : 8'h0a);
         // Dropping one enable keeps its flag but silences its request
         wr(8'he8, 8'h0d);
         repeat (2) @(posedge core_clk_i);
         #1;
         chk({edge_irq_line_one_o, edge_irq_line_zero_o}, {pe, 1'b0});
         rd(8'he8, d);
         chk(d, pe ? 8'h0d : 8'h08);
         wr(8'he8, 8'h08);
         rd(8'he8, d);
         chk(d, 8'h08);
         chk({edge_irq_line_one_o, edge_irq_line_zero_o}, 2'h0);
         wr(8'hf0, 8'h03);
      end
      results();
   end
endmodule
